// file: logic/tti_map.vh
// Constants for the touch report I2C target
`ifndef TTI_MAP_VH
`define TTI_MAP_VH
`define TTI_ADDR       7'h2a
`define TTI_DIR_READ   1'b1
`define TTI_PAYLOAD    7'h40
`define TTI_LEN_OVH    8'h02
`define TTI_IDX_LEN_LO 7'h00
`define TTI_IDX_LEN_HI 7'h01
`define TTI_IDX_DATA   7'h02
`define TTI_IDX_ONE    7'h01
`define TTI_CNT_ZERO   7'h00
`define TTI_BIT_LAST   3'h7
`define TTI_BIT_ONE    3'h1
`define TTI_BIT_ZERO   3'h0
`define TTI_BYTE_ZERO  8'h00
`define TTI_FIFO_W     8
`define TTI_FIFO_D     32
`define TTI_FIFO_AW    5
`endif

// file: logic/tti_touch_target.v
// Touch report I2C target with report FIFO and interrupt request
//
// What this block does
// R1: Answers only at seven-bit address 0x2A.
// R2: One report packet per transaction frame.
// R3: Request line is active low, level type.
// R4: Request held low while buffer holds data.
// R5: Host should clock at 400 kHz; the bench host model clocks SCL at 5 MHz.
// R6: Direction bit high reads, low writes.
// R7: Ack low, nack high on ninth clock.
// R8: Host drives dimming PWM 100 Hz to 50 kHz.
// R9: Clear line returns controller to initial state.
// R10: Host reads 66 bytes, nacks the last.
// R11: Length first, LSB first, counts itself.
// R12: Target only, never starts bus traffic.
`timescale 1ns/1ps
`include "tti_map.vh"

// Byte FIFO between report source and I2C transmitter
module tti_fifo #(
    parameter W  = 8,
    parameter D  = 32,
    parameter AW = 5
) (
    // Clock, reset, enable, clear
    input  wire          clk_in,
    input  wire          rst_in,
    input  wire          ce_in,
    input  wire          clr_in,
    // Fill side
    input  wire [W-1:0]  in_data_in,
    input  wire          in_valid_in,
    output wire          in_ready_out,
    // Drain side
    output wire [W-1:0]  out_data_out,
    output wire          out_valid_out,
    input  wire          out_ready_in
);
    localparam [AW:0] DEPTH_C = D;       // Depth at counter width
    localparam [AW:0] ONE_C   = 1;       // Counter step

    reg [W-1:0]  mem_q [0:D-1];          // Storage array
    reg [AW-1:0] wptr_q;                 // Write pointer
    reg [AW-1:0] rptr_q;                 // Read pointer
    reg [AW:0]   count_q;                // Words held
    wire         push;                   // Word accepted
    wire         pop;                    // Word taken

    assign in_ready_out  = (count_q != DEPTH_C);
    assign out_valid_out = (count_q != {(AW+1){1'b0}});
    assign out_data_out  = mem_q[rptr_q];
    assign push = in_valid_in & in_ready_out;
    assign pop  = out_ready_in & out_valid_out;

    // Storage write, no reset needed
    always @(posedge clk_in) begin
        if (ce_in && push) begin
            mem_q[wptr_q] <= in_data_in;
        end
    end

    // Pointers and occupancy
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wptr_q  <= {AW{1'b0}};
            rptr_q  <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else if (ce_in) begin
            if (clr_in) begin
                // Clear empties the buffer
                wptr_q  <= {AW{1'b0}};
                rptr_q  <= {AW{1'b0}};
                count_q <= {(AW+1){1'b0}};
            end else begin
                if (push) begin
                    wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
                end
                if (pop) begin
                    rptr_q <= rptr_q + {{(AW-1){1'b0}}, 1'b1};
                end
                if (push && !pop) begin
                    count_q <= count_q + ONE_C;
                end else if (pop && !push) begin
                    count_q <= count_q - ONE_C;
                end
            end
        end
    end
endmodule // tti_fifo

// Top: I2C target serving one report per read frame
module tti_touch_target (
    // Clock, reset, enable
    input  wire       core_clk_in,
    input  wire       rst_in,
    input  wire       clk_en_in,
    // I2C pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe_out,
    // Request and controller clear pins
    output wire       touch_irq_n_out,
    input  wire       controller_clear_n_in,
    // Backlight dimming
    input  wire       backlight_dimming_pwm_in,
    output wire       backlight_drive_out,
    // Report source stream
    input  wire [7:0] report_data_in,
    input  wire       report_valid_in,
    output wire       report_ready_out
);
    // One-hot protocol states
    localparam [6:0] ST_IDLE = 7'h01;    // Bus idle or not addressed
    localparam [6:0] ST_ADDR = 7'h02;    // Shifting address byte
    localparam [6:0] ST_AACK = 7'h04;    // Acking our address
    localparam [6:0] ST_TX   = 7'h08;    // Sending a byte
    localparam [6:0] ST_TACK = 7'h10;    // Host ack slot
    localparam [6:0] ST_RX   = 7'h20;    // Receiving a written byte
    localparam [6:0] ST_RACK = 7'h40;    // Acking a written byte

    // Synchronisers, first stage read only by second
    reg [1:0] scl_s_q;                   // SCL sync chain
    reg [1:0] sda_s_q;                   // SDA sync chain
    reg [1:0] clr_s_q;                   // Clear sync chain
    reg [1:0] pwm_s_q;                   // PWM sync chain
    reg       scl_prev_q;                // SCL one cycle back
    reg       sda_prev_q;                // SDA one cycle back

    // Protocol state
    reg [6:0] st_q;                      // Current state
    reg [2:0] bit_q;                     // Bit counter in byte
    reg       done_q;                    // Eight bits seen
    reg [7:0] sh_q;                      // Shift register
    reg       rw_q;                      // Direction of frame
    reg [6:0] idx_q;                     // Byte index in frame
    reg [6:0] left_q;                    // Payload bytes still owed
    reg [6:0] flush_q;                   // Bytes to discard
    reg [7:0] len_q;                     // Length low byte
    reg       oe_q;                      // Drive SDA low
    reg       irq_n_q;                   // Request line
    reg       pwm_q;                     // Backlight drive

    // Combinational helpers
    wire       scl_s;                    // Synced SCL
    wire       sda_s;                    // Synced SDA
    wire       scl_rise;                 // SCL rising edge
    wire       scl_fall;                 // SCL falling edge
    wire       start_c;                  // Start or repeated start
    wire       stop_c;                   // Stop
    wire       clear_c;                  // Controller clear active
    wire       run_c;                    // Normal protocol step
    wire       addr_hit;                 // Our address matched
    wire       load_c;                   // Load next byte to send
    wire       hdr_pop;                  // Take packet count word
    wire       dat_pop;                  // Take payload byte
    wire       flush_pop;                // Discard stale byte
    wire       f_valid;                  // FIFO holds data
    wire [7:0] f_data;                   // FIFO head
    reg  [7:0] next_byte;                // Byte to load

    assign scl_s     = scl_s_q[1];
    assign sda_s     = sda_s_q[1];
    assign scl_rise  = scl_s & ~scl_prev_q;
    assign scl_fall  = ~scl_s & scl_prev_q;
    assign start_c   = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_c    = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    assign clear_c   = ~clr_s_q[1];
    assign run_c     = ~clear_c & ~start_c & ~stop_c;
    assign addr_hit  = (sh_q[7:1] == `TTI_ADDR); // R1
    // Count word opens each packet; taken only on a read to us
    assign hdr_pop   = run_c & st_q[1] & scl_fall & done_q & addr_hit
                     & (sh_q[0] == `TTI_DIR_READ) & f_valid
                     & (flush_q == `TTI_CNT_ZERO); // R2 R6
    assign load_c    = run_c & scl_fall & ((st_q[2] & rw_q) | st_q[4]);
    assign dat_pop   = load_c & (idx_q >= `TTI_IDX_DATA)
                     & (left_q != `TTI_CNT_ZERO) & f_valid;
    assign flush_pop = ~clear_c & (flush_q != `TTI_CNT_ZERO) & f_valid; // R2

    // Report buffer, clear empties it
    tti_fifo #(
        .W  (`TTI_FIFO_W),
        .D  (`TTI_FIFO_D),
        .AW (`TTI_FIFO_AW)
    ) u_fifo (
        .clk_in        (core_clk_in),
        .rst_in        (rst_in),
        .ce_in         (clk_en_in),
        .clr_in        (clear_c),
        .in_data_in    (report_data_in),
        .in_valid_in   (report_valid_in),
        .in_ready_out  (report_ready_out),
        .out_data_out  (f_data),
        .out_valid_out (f_valid),
        .out_ready_in  (hdr_pop | dat_pop | flush_pop)
    );

    // Pick next outgoing byte: length, then payload or padding
    always @* begin
        next_byte = `TTI_BYTE_ZERO;
        if (idx_q == `TTI_IDX_LEN_LO) begin
            next_byte = len_q; // R11
        end else if (idx_q == `TTI_IDX_LEN_HI) begin
            next_byte = `TTI_BYTE_ZERO; // R11
        end else if ((left_q != `TTI_CNT_ZERO) && f_valid) begin
            next_byte = f_data;
        end
    end

    // Pin synchronisers and edge history
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_s_q    <= 2'h3;
            sda_s_q    <= 2'h3;
            clr_s_q    <= 2'h3;
            pwm_s_q    <= 2'h0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (clk_en_in) begin
            scl_s_q    <= {scl_s_q[0], scl_in};
            sda_s_q    <= {sda_s_q[0], sda_in};
            clr_s_q    <= {clr_s_q[0], controller_clear_n_in};
            pwm_s_q    <= {pwm_s_q[0], backlight_dimming_pwm_in};
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // Request line and backlight drive
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_n_q <= 1'b1;
            pwm_q   <= 1'b0;
        end else if (clk_en_in) begin
            irq_n_q <= ~f_valid; // R3 R4 R12
            pwm_q   <= pwm_s_q[1]; // R8
        end
    end

    // Protocol engine; target only, drives SDA low or releases it
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q    <= ST_IDLE;
            bit_q   <= `TTI_BIT_ZERO;
            done_q  <= 1'b0;
            sh_q    <= `TTI_BYTE_ZERO;
            rw_q    <= 1'b0;
            idx_q   <= `TTI_CNT_ZERO;
            left_q  <= `TTI_CNT_ZERO;
            flush_q <= `TTI_CNT_ZERO;
            len_q   <= `TTI_BYTE_ZERO;
            oe_q    <= 1'b0;
        end else if (clk_en_in) begin
            if (clear_c) begin
                // Clear returns every field to its initial value
                st_q    <= ST_IDLE; // R9
                bit_q   <= `TTI_BIT_ZERO;
                done_q  <= 1'b0;
                sh_q    <= `TTI_BYTE_ZERO;
                rw_q    <= 1'b0;
                idx_q   <= `TTI_CNT_ZERO;
                left_q  <= `TTI_CNT_ZERO;
                flush_q <= `TTI_CNT_ZERO; // R9
                len_q   <= `TTI_BYTE_ZERO;
                oe_q    <= 1'b0;
            end else if (start_c || stop_c) begin
                // Frame ends: unread payload is discarded, never resent
                if (left_q != `TTI_CNT_ZERO) begin
                    // A discard in the same cycle must still be counted off
                    flush_q <= flush_q + left_q
                             - (flush_pop ? `TTI_IDX_ONE : `TTI_CNT_ZERO); // R2
                end else if (flush_pop) begin
                    flush_q <= flush_q - `TTI_IDX_ONE;
                end
                left_q <= `TTI_CNT_ZERO;
                oe_q   <= 1'b0;
                bit_q  <= `TTI_BIT_ZERO;
                done_q <= 1'b0;
                st_q   <= start_c ? ST_ADDR : ST_IDLE;
            end else begin
                // Background discard of stale bytes
                if (flush_pop) begin
                    flush_q <= flush_q - `TTI_IDX_ONE;
                end
                // Shared bit counting on rising SCL
                if (scl_rise && (st_q[1] || st_q[3] || st_q[5])) begin
                    bit_q  <= bit_q + `TTI_BIT_ONE;
                    done_q <= (bit_q == `TTI_BIT_LAST);
                    if (!st_q[3]) begin
                        sh_q <= {sh_q[6:0], sda_s};
                    end
                end
                case (st_q)
                    ST_IDLE: begin
                        oe_q <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (scl_fall && done_q) begin
                            done_q <= 1'b0;
                            if (addr_hit) begin
                                // Ack our address by pulling SDA low
                                oe_q  <= 1'b1; // R1 R7
                                rw_q  <= sh_q[0]; // R6
                                idx_q <= `TTI_CNT_ZERO;
                                st_q  <= ST_AACK;
                                if (hdr_pop) begin
                                    len_q  <= f_data + `TTI_LEN_OVH; // R11
                                    left_q <= `TTI_PAYLOAD; // R10
                                end else begin
                                    len_q  <= `TTI_BYTE_ZERO;
                                    left_q <= `TTI_CNT_ZERO;
                                end
                            end else begin
                                st_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            if (rw_q) begin
                                // Read: put first length byte out
                                sh_q  <= next_byte;
                                oe_q  <= ~next_byte[7];
                                idx_q <= idx_q + `TTI_IDX_ONE;
                                st_q  <= ST_TX;
                            end else begin
                                oe_q <= 1'b0;
                                st_q <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (done_q) begin
                                // Release SDA for host ack slot
                                done_q <= 1'b0;
                                oe_q   <= 1'b0; // R7
                                st_q   <= ST_TACK;
                            end else begin
                                sh_q <= {sh_q[6:0], 1'b0};
                                oe_q <= ~sh_q[6];
                            end
                        end
                    end
                    ST_TACK: begin
                        if (scl_rise && sda_s) begin
                            st_q <= ST_IDLE; // R7 R10
                        end else if (scl_fall) begin
                            // Host acked: next byte
                            sh_q  <= next_byte;
                            oe_q  <= ~next_byte[7];
                            idx_q <= idx_q + `TTI_IDX_ONE;
                            st_q  <= ST_TX;
                            if (dat_pop) begin
                                left_q <= left_q - `TTI_IDX_ONE;
                            end
                        end
                    end
                    ST_RX: begin
                        if (scl_fall && done_q) begin
                            // Written bytes are acked and dropped
                            done_q <= 1'b0;
                            oe_q   <= 1'b1; // R7
                            st_q   <= ST_RACK;
                        end
                    end
                    ST_RACK: begin
                        if (scl_fall) begin
                            oe_q <= 1'b0;
                            st_q <= ST_RX;
                        end
                    end
                    default: begin
                        st_q <= ST_IDLE;
                        oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open-drain data: only ever pulls low
    assign sda_out             = 1'b0;
    assign sda_oe_out          = oe_q;
    assign touch_irq_n_out     = irq_n_q;
    assign backlight_drive_out = pwm_q;
endmodule // tti_touch_target

// file: verification/tti_touch_target_properties.sv
// Pin-level checker for the touch report I2C target
`timescale 1ns/1ps
module tti_touch_props (
    // Clock, reset, enable
    input wire core_clk_in,
    input wire rst_in,
    input wire clk_en_in,
    // Serial, request and clear pins
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe_out,
    input wire touch_irq_n_out,
    input wire controller_clear_n_in,
    // Dimming and report stream
    input wire backlight_dimming_pwm_in,
    input wire backlight_drive_out,
    input wire report_valid_in,
    input wire report_ready_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // Request is low two cycles after an accepted byte (registered behind the FIFO flag)
    irq_on_push_a: assert property (
        report_valid_in && report_ready_out && clk_en_in && controller_clear_n_in
        && $past(controller_clear_n_in, 3) |=> ##1 !touch_irq_n_out)
        else $error("request line stayed high after a push");
    // A full buffer always has data pending
    full_means_pending_a: assert property (
        !report_ready_out && controller_clear_n_in && $past(controller_clear_n_in, 3)
        |-> !touch_irq_n_out)
        else $error("buffer full but request line high");
    // Released request means the buffer has room
    idle_means_room_a: assert property (
        touch_irq_n_out |-> report_ready_out)
        else $error("request released while buffer full");
    // Quiet pins right after reset
    release_state_a: assert property (
        $fell(rst_in) |-> touch_irq_n_out && !sda_oe_out && report_ready_out)
        else $error("outputs not idle after reset");
    // Held clear empties everything
    clear_empties_a: assert property (
        (!controller_clear_n_in && clk_en_in) [*6] |=>
        touch_irq_n_out && report_ready_out && !sda_oe_out)
        else $error("clear did not return to idle");
    // Open drain only ever pulls low
    ack_low_only_a: assert property (
        sda_out == 1'b0)
        else $error("data value not low");
    // No data change while clock high, so no start or stop from us
    target_only_a: assert property (
        scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3)
        |-> $stable(sda_oe_out))
        else $error("data line moved while clock high");
    // Backlight drive follows the dimming input
    dimming_follow_a: assert property (
        clk_en_in && $past(clk_en_in) && $past(clk_en_in, 2)
        |-> backlight_drive_out == $past(backlight_dimming_pwm_in, 3))
        else $error("backlight drive does not follow input");
    // Main scenarios reached
    cover property (report_valid_in && report_ready_out);
    cover property ($rose(sda_oe_out));
    cover property (!report_ready_out);
    cover property (!controller_clear_n_in [*6]);
endmodule // tti_touch_props

bind tti_touch_target tti_touch_props u_props (
    .core_clk_in             (core_clk_in),
    .rst_in                  (rst_in),
    .clk_en_in               (clk_en_in),
    .scl_in                  (scl_in),
    .sda_out                 (sda_out),
    .sda_oe_out              (sda_oe_out),
    .touch_irq_n_out         (touch_irq_n_out),
    .controller_clear_n_in   (controller_clear_n_in),
    .backlight_dimming_pwm_in(backlight_dimming_pwm_in),
    .backlight_drive_out     (backlight_drive_out),
    .report_valid_in         (report_valid_in),
    .report_ready_out        (report_ready_out)
);

// file: verification/tti_host_model.sv
// Host I2C controller model for the touch report target
`timescale 1ns/1ps
module tti_host_model (
    // Serial lines
    output logic scl_out,
    output logic sda_out,  // High releases to pull-up
    input  wire  sda_in
);
    // Clock stands high between frames
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // Start: data falls while clock high
    task automatic start();
        sda_out = 1'b1;
        scl_out = 1'b1;
        #100 sda_out = 1'b0;
        #100 scl_out = 1'b0;
    endtask
    // Stop: data rises while clock high
    task automatic stop();
        sda_out = 1'b0;
        #100 scl_out = 1'b1;
        #100 sda_out = 1'b1;
        #200;
    endtask
    // Eight bits MSB first, then the acknowledge slot; 200 ns clock
    task automatic xfer(input [7:0] tx, input logic ak, output [7:0] rx, output logic ar);
        int i;
        for (i = 7; i >= -1; i--) begin
            sda_out = (i < 0) ? ak : tx[i];
            #100 scl_out = 1'b1;
            #50;
            if (i >= 0) rx[i] = sda_in;
            else ar = sda_in;
            #50 scl_out = 1'b0;
        end
    endtask
endmodule // tti_host_model

// file: verification/test_touch_report_i2c_target.sv
// Self-checking bench for the touch report I2C target
`timescale 1ns/1ps
module test_touch_report_i2c_target;
    // Bench drives and observed pins
    logic       core_clk;
    logic       rst;
    logic       pwm;
    logic       clr_n;
    logic       valid;
    logic [7:0] data;
    wire        ready;
    wire        irq_n;
    wire        oe;
    wire        drv;
    wire        scl;
    wire        host_sda;
    wire        sda_w = host_sda & ~oe;  // Pulled-up open drain wire
    int         n_mismatch = 0;
    int         n_checks = 0;
    // Ordinary cases: count word beside the length it reads back as
    typedef struct { logic [7:0] n; logic [7:0] len; } tti_row_t;
    tti_row_t rows [3] = '{'{8'h00, 8'h02}, '{8'h40, 8'h42}, '{8'h11, 8'h13}};

    tti_touch_target u_dut (
        .core_clk_in             (core_clk),
        .rst_in                  (rst),
        .clk_en_in               (1'b1),
        .scl_in                  (scl),
        .sda_in                  (sda_w),
        .sda_out                 (),
        .sda_oe_out              (oe),
        .touch_irq_n_out         (irq_n),
        .controller_clear_n_in   (clr_n),
        .backlight_dimming_pwm_in(pwm),
        .backlight_drive_out     (drv),
        .report_data_in          (data),
        .report_valid_in         (valid),
        .report_ready_out        (ready)
    );
    tti_host_model u_host (.scl_out(scl), .sda_out(host_sda), .sda_in(sda_w));

    // 40 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Payload pattern of a packet
    function automatic [7:0] pay(input [7:0] n, input int i);
        return n + 8'(i) + 8'h30;
    endfunction
    // Compare helpers
    task automatic cmp_byte(input [7:0] got, input [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: bit %b, want %b", $time, got, exp);
        end
    endtask
    // Offer one byte, hold until ready seen
    task automatic push(input [7:0] b);
        int t;
        @(negedge core_clk);
        data = b;
        valid = 1'b1;
        for (t = 0; t < 4000 && ready !== 1'b1; t++) @(negedge core_clk);
    endtask
    // Count word then cnt payload bytes
    task automatic push_pkt(input [7:0] n, input int cnt);
        int i;
        push(n);
        for (i = 0; i < cnt; i++) push(pay(n, i));
        @(negedge core_clk);
        valid = 1'b0;
    endtask
    // Bounded wait for a request level
    task automatic wait_irq(input logic v);
        int t;
        for (t = 0; t < 400 && irq_n !== v; t++) @(negedge core_clk);
    endtask
    // Read frame of nb bytes, last one not acknowledged
    task automatic read_frame(input [7:0] n, input [7:0] len, input logic e, input int nb);
        logic [7:0] rx;
        logic [7:0] ex;
        logic       k;
        int         i;
        u_host.start();
        u_host.xfer({7'h2a, 1'b1}, 1'b1, rx, k);
        cmp_bit(k, 1'b0);
        for (i = 0; i < nb; i++) begin
            u_host.xfer(8'hff, i == nb - 1, rx, k);
            ex = e ? 8'h00 : (i == 0 ? len : (i == 1 ? 8'h00 : pay(n, i - 2)));
            cmp_byte(rx, ex);
        end
        u_host.stop();
    endtask
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        #2000000;
        n_mismatch++;
        complete_run();
    end
    // Main sequence
    initial begin
        logic [7:0] rx;
        logic       k;
        int         r;
        rst = 1'b1;
        pwm = 1'b0;
        clr_n = 1'b1;
        valid = 1'b0;
        data = 8'h00;
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        cmp_bit(irq_n, 1'b1);
        cmp_bit(oe, 1'b0);
        // Table rows: stream a packet while the host reads it
        for (r = 0; r < 3; r++) begin
            fork
                push_pkt(rows[r].n, 64);
                begin
                    wait_irq(1'b0);
                    read_frame(rows[r].n, rows[r].len, 1'b0, 66);
                end
            join
            wait_irq(1'b1);
            cmp_bit(irq_n, 1'b1);
        end
        // Empty buffer reads a zero length
        read_frame(8'h00, 8'h00, 1'b1, 3);
        // Foreign address gets no acknowledge
        u_host.start();
        u_host.xfer({7'h2b, 1'b1}, 1'b1, rx, k);
        cmp_bit(k, 1'b1);
        u_host.stop();
        // Write direction acknowledged and ignored
        u_host.start();
        u_host.xfer({7'h2a, 1'b0}, 1'b1, rx, k);
        cmp_bit(k, 1'b0);
        u_host.xfer(8'h5a, 1'b1, rx, k);
        cmp_bit(k, 1'b0);
        u_host.stop();
        cmp_bit(irq_n, 1'b1);
        // Frame cut short: rest of packet is not carried over
        fork
            push_pkt(8'h09, 64);
            begin
                wait_irq(1'b0);
                read_frame(8'h09, 8'h0b, 1'b0, 4);
            end
        join
        wait_irq(1'b1);
        read_frame(8'h00, 8'h00, 1'b1, 2);
        // Fill the buffer to refusal, then clear it
        push_pkt(8'h05, 31);
        cmp_bit(ready, 1'b0);
        cmp_bit(irq_n, 1'b0);
        clr_n = 1'b0;
        repeat (6) @(negedge core_clk);
        clr_n = 1'b1;
        repeat (6) @(negedge core_clk);
        cmp_bit(irq_n, 1'b1);
        cmp_bit(ready, 1'b1);
        // Backlight follows dimming input
        pwm = 1'b1;
        repeat (5) @(negedge core_clk);
        cmp_bit(drv, 1'b1);
        complete_run();
    end
endmodule // test_touch_report_i2c_target
